// ===== rxqa_core.sv
/*
  Receive queue assignment: picks one of 128 receive queues per packet
  decision from Ethertype filters, SYN and flow-steering match results and
  hash spreading, with or without virtualization pools. Holds the filter
  and scheme registers behind an Avalon-MM slave.
  Assumes packet requests come from logic on sys_clk_i and that the
  downstream DMA takes one decision per cycle without back-pressure.
*/
// How it works
// - Ethertype, then SYN, flow steering, hash, zero
// - Eight Ethertype filters, match plus steer register
// - Plain scheme sends unclaimed packets to queue 0
// - Hash scheme spreads over 64 queues
// - Scheme field in control register picks scheme
// - Virtualization splits 128 queues into pools, equal except in the 62/63-pool layouts
// - No hash: pool N default queue 2N/4N/8N
// - Hash pools: 32 of four or 64 of two
// - 63-pool layout: pool 62 wide, 63 off
// - 62-pool layout: pools 60,62 wide, 61,63 off
// - Scheme 0xF gives 62 pools, 0x0 gives 63
// - Pool index high bits, hash index low bits
// - Disabled filter is ignored, except filter 0's pool enable, which diverts non-mirror packets that no filter matches
// - Match on 16-bit type alone
// - Report matching filter number downstream
// - Ethertype match forces delivery to host
// - Time-stamp bit marks packet as time protocol
// - Queue enable clear means no steering
// - Pool enable diverts; only that copy steered
module rxqa_core
(
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        pkt_valid_i,
  input  wire logic [15:0] pkt_ethertype_i,
  input  wire logic [5:0]  pkt_pool_i,
  input  wire logic        pkt_mirror_i,
  input  wire logic [6:0]  pkt_hash_i,
  input  wire logic        syn_match_i,
  input  wire logic [6:0]  syn_queue_i,
  input  wire logic        fd_match_i,
  input  wire logic [6:0]  fd_queue_i,
  output logic             dec_valid_o,
  output logic      [6:0]  dec_queue_o,
  output logic      [5:0]  dec_pool_o,
  output logic             dec_pool_off_o,
  output logic             dec_etf_hit_o,
  output logic      [2:0]  dec_etf_id_o,
  output logic             dec_timestamp_o,
  output logic             dec_host_force_o
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] etf_match [rxqa_pkg::NUM_ETF];
  logic [31:0] etf_steer [rxqa_pkg::NUM_ETF];
  logic [3:0]  scheme;
  logic        vt_en;
  logic [15:0] dec_count;
  logic        bus_take;
  logic        bus_read;
  logic [3:0]  match_idx;
  logic [3:0]  steer_idx;
  logic [31:0] status_word;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Index of a filter register, or eight when the address misses the bank
  function automatic logic [3:0] bank_idx(input logic [7:0] a,
                                          input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    if (a >= base && d < 8'h20 && d[1:0] == 2'b00)
      bank_idx = {1'b0, d[4:2]};
    else
      bank_idx = 4'h8;
  endfunction

  // ----------------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------------
  // Waitrequest drops for one cycle per request
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      avs_waitrequest_o <= 1'b1;
    else if ((avs_read_i || avs_write_i) && avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  assign bus_take  = avs_write_i && !avs_waitrequest_o;
  assign bus_read  = avs_read_i && avs_waitrequest_o;
  assign match_idx = bank_idx(avs_address_i, rxqa_pkg::OFS_MATCH);
  assign steer_idx = bank_idx(avs_address_i, rxqa_pkg::OFS_STEER);

  // ----------------------------------------------------------------------
  // Filter and scheme registers
  // ----------------------------------------------------------------------
  generate
    for (genvar i = 0; i < rxqa_pkg::NUM_ETF; i++)
    begin : g_etf_regs
      always_ff @(posedge sys_clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          etf_match[i] <= rxqa_pkg::RST_MATCH;
          etf_steer[i] <= rxqa_pkg::RST_STEER;
        end
        else if (bus_take)
        begin
          if (match_idx == 4'(i))
            etf_match[i] <= avs_writedata_i;
          if (steer_idx == 4'(i))
            etf_steer[i] <= avs_writedata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      scheme <= rxqa_pkg::RST_SCHEME;
      vt_en  <= rxqa_pkg::RST_VT_EN;
    end
    else if (bus_take)
    begin
      if (avs_address_i == rxqa_pkg::OFS_MQC)
        scheme <= avs_writedata_i[rxqa_pkg::MQC_SCH_LSB +: 4];
      else if (avs_address_i == rxqa_pkg::OFS_VTCTL)
        vt_en <= avs_writedata_i[rxqa_pkg::VT_EN_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  assign status_word = {dec_count, 9'h000, dec_queue_o};

  // Read data is loaded on the edge that drops waitrequest
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (bus_read)
    begin
      if (match_idx != 4'h8)
        avs_readdata_o <= etf_match[match_idx[2:0]];
      else if (steer_idx != 4'h8)
        avs_readdata_o <= etf_steer[steer_idx[2:0]];
      else if (avs_address_i == rxqa_pkg::OFS_MQC)
        avs_readdata_o <= {28'h000_0000, scheme};
      else if (avs_address_i == rxqa_pkg::OFS_VTCTL)
        avs_readdata_o <= {31'h0000_0000, vt_en};
      else if (avs_address_i == rxqa_pkg::OFS_STATUS)
        avs_readdata_o <= status_word;
      else
        avs_readdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Ethertype filters
  // ----------------------------------------------------------------------
  logic [rxqa_pkg::NUM_ETF-1:0] etf_hit;

  generate
    for (genvar i = 0; i < rxqa_pkg::NUM_ETF; i++)
    begin : g_etf_cmp
      assign etf_hit[i] = etf_match[i][rxqa_pkg::MT_ENABLE] &&
        (etf_match[i][rxqa_pkg::MT_TYPE_LSB +: 16] == pkt_ethertype_i);
    end
  endgenerate

  logic        any_hit;
  logic [2:0]  hit_id;
  logic [31:0] hit_match;
  logic [31:0] hit_steer;
  logic [5:0]  hit_pool;
  logic        hit_pool_en;
  logic        etf_steers;

  // Lowest numbered filter wins if software overlaps them
  always_comb
  begin
    hit_id = 3'h0;
    for (int i = rxqa_pkg::NUM_ETF - 1; i >= 0; i--)
      if (etf_hit[i])
        hit_id = 3'(i);
  end

  assign any_hit     = |etf_hit;
  assign hit_match   = etf_match[hit_id];
  assign hit_steer   = etf_steer[hit_id];
  assign hit_pool    = hit_match[rxqa_pkg::MT_POOL_LSB +: 6];
  assign hit_pool_en = vt_en && hit_match[rxqa_pkg::MT_POOL_EN];

  // Pool-diverted filters steer only the copy aimed at their pool
  assign etf_steers = any_hit && hit_steer[rxqa_pkg::ST_QUEUE_EN] &&
    (!hit_pool_en || !pkt_mirror_i || (pkt_pool_i == hit_pool));

  // ----------------------------------------------------------------------
  // Pool layouts
  // ----------------------------------------------------------------------
  logic [5:0] eff_pool;
  logic [6:0] spread_q;
  logic       pool_off;
  logic       divert;

  // Mirror copies keep the pool that mirroring gave them
  assign divert   = hit_pool_en && !pkt_mirror_i;
  assign eff_pool = divert ? hit_pool : pkt_pool_i;

  always_comb
  begin
    spread_q = 7'h00;
    pool_off = 1'b0;
    if (!vt_en)
    begin
      if (scheme == rxqa_pkg::SCH_HASH)
        spread_q = {1'b0, pkt_hash_i[5:0]};
      else
        spread_q = 7'h00;
    end
    else
    begin
      case (scheme)
        rxqa_pkg::SCH_VT_H64:
          spread_q = {eff_pool, pkt_hash_i[0]};
        rxqa_pkg::SCH_VT_H32:
          spread_q = {eff_pool[4:0], pkt_hash_i[1:0]};
        rxqa_pkg::SCH_VT_N16:
          spread_q = {eff_pool[3:0], 3'h0};
        rxqa_pkg::SCH_VT_N32:
          spread_q = {eff_pool[4:0], 2'h0};
        rxqa_pkg::SCH_VT_N64:
          spread_q = {eff_pool, 1'b0};
        rxqa_pkg::SCH_VT_P63:
        begin
          if (eff_pool == rxqa_pkg::POOL_OFF_HI)
            pool_off = 1'b1;
          else if (eff_pool == rxqa_pkg::POOL_WIDE_HI)
            spread_q = {eff_pool[5:1], pkt_hash_i[1:0]};
          else
            spread_q = {eff_pool, pkt_hash_i[0]};
        end
        rxqa_pkg::SCH_VT_P62:
        begin
          if (eff_pool == rxqa_pkg::POOL_OFF_LO ||
              eff_pool == rxqa_pkg::POOL_OFF_HI)
            pool_off = 1'b1;
          else if (eff_pool == rxqa_pkg::POOL_WIDE_LO ||
                   eff_pool == rxqa_pkg::POOL_WIDE_HI)
            spread_q = {eff_pool[5:1], pkt_hash_i[1:0]};
          else
            spread_q = {eff_pool, pkt_hash_i[0]};
        end
        default:
          spread_q = {eff_pool, 1'b0};
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Priority selection
  // ----------------------------------------------------------------------
  logic [6:0] next_queue;
  logic       pool_blocked;

  // A disabled pool gets queue zero unless a filter steers it
  assign pool_blocked = pool_off && !etf_steers;

  always_comb
  begin
    if (etf_steers)
      next_queue = hit_steer[rxqa_pkg::ST_QUEUE_LSB +: 7];
    else if (syn_match_i && !pkt_mirror_i)
      next_queue = syn_queue_i;
    else if (fd_match_i)
      next_queue = fd_queue_i;
    else
      next_queue = spread_q;
  end

  // ----------------------------------------------------------------------
  // Decision outputs
  // ----------------------------------------------------------------------
  // Decision registers, one per packet request
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dec_valid_o      <= 1'b0;
      dec_queue_o      <= 7'h00;
      dec_pool_o       <= 6'h00;
      dec_pool_off_o   <= 1'b0;
      dec_etf_hit_o    <= 1'b0;
      dec_etf_id_o     <= 3'h0;
      dec_timestamp_o  <= 1'b0;
      dec_host_force_o <= 1'b0;
    end
    else
    begin
      dec_valid_o <= pkt_valid_i;
      if (pkt_valid_i)
      begin
        dec_queue_o      <= pool_blocked ? 7'h00 : next_queue;
        dec_pool_o       <= eff_pool;
        dec_pool_off_o   <= pool_blocked;
        dec_etf_hit_o    <= any_hit;
        dec_etf_id_o     <= any_hit ? hit_id : 3'h0;
        dec_timestamp_o  <= any_hit &&
                            hit_match[rxqa_pkg::MT_TSTAMP];
        dec_host_force_o <= any_hit;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Decision counter
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      dec_count <= 16'h0000;
    else if (pkt_valid_i)
      dec_count <= dec_count + 16'h0001;
  end

endmodule // rxqa_core

// ===== rxqa_core_tb.sv
/*
  Self-checking bench for rxqa_core: register access, scheme table, and
  priority and back-to-back cases.
  Assumes the checker is bound by its own file.
*/
module rxqa_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [3:0] sch; logic vt; logic [15:0] et;
    logic [5:0] pool; logic [6:0] hash; logic [6:0] q; logic [2:0] fl;
    logic [2:0] id;} rxqa_row_t;
  logic sys_clk_i, nrst_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic pkt_valid_i, pkt_mirror_i, syn_match_i, fd_match_i, dec_valid_o;
  logic dec_pool_off_o, dec_etf_hit_o, dec_timestamp_o, dec_host_force_o;
  logic [7:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [15:0] pkt_ethertype_i;
  logic [6:0]  pkt_hash_i, syn_queue_i, fd_queue_i, dec_queue_o, got_q, prev_q;
  logic [5:0]  pkt_pool_i, dec_pool_o;
  logic [2:0]  dec_etf_id_o, got_fl, got_id;
  int          fails, samples_checked, ndec;
  // Columns: scheme, virt, type, pool, hash, queue, {off,hit,ts}, id
  rxqa_row_t rows [19] = '{
    '{4'h0,1'h0,16'h0800,6'h00,7'h2A,7'h00,3'h0,3'h0},
    '{4'h1,1'h0,16'h0800,6'h00,7'h6A,7'h2A,3'h0,3'h0},
    '{4'hC,1'h1,16'h0800,6'h03,7'h00,7'h18,3'h0,3'h0},
    '{4'hD,1'h1,16'h0800,6'h03,7'h00,7'h0C,3'h0,3'h0},
    '{4'hE,1'h1,16'h0800,6'h03,7'h00,7'h06,3'h0,3'h0},
    '{4'hA,1'h1,16'h0800,6'h05,7'h03,7'h17,3'h0,3'h0},
    '{4'hB,1'h1,16'h0800,6'h05,7'h01,7'h0B,3'h0,3'h0},
    '{4'h5,1'h1,16'h0800,6'h07,7'h01,7'h0E,3'h0,3'h0},
    '{4'h0,1'h1,16'h0800,6'h3E,7'h02,7'h7E,3'h0,3'h0},
    '{4'h0,1'h1,16'h0800,6'h3F,7'h00,7'h00,3'h4,3'h0},
    '{4'h0,1'h1,16'h0800,6'h3D,7'h00,7'h7A,3'h0,3'h0},
    '{4'hF,1'h1,16'h0800,6'h3C,7'h01,7'h79,3'h0,3'h0},
    '{4'hF,1'h1,16'h0800,6'h3D,7'h00,7'h00,3'h4,3'h0},
    '{4'hF,1'h1,16'h0800,6'h3B,7'h00,7'h76,3'h0,3'h0},
    '{4'h1,1'h0,16'h88F7,6'h00,7'h01,7'h05,3'h3,3'h0},
    '{4'h1,1'h0,16'h88CC,6'h00,7'h09,7'h09,3'h2,3'h7},
    '{4'h1,1'h0,16'h1234,6'h00,7'h01,7'h01,3'h0,3'h0},
    '{4'hE,1'h1,16'h888E,6'h05,7'h00,7'h0A,3'h2,3'h3},
    '{4'hE,1'h1,16'h888E,6'h04,7'h00,7'h0A,3'h2,3'h3}};

  rxqa_core u_rxqa_core (.sys_clk_i, .nrst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .pkt_valid_i, .pkt_ethertype_i, .pkt_pool_i, .pkt_mirror_i, .pkt_hash_i,
    .syn_match_i, .syn_queue_i, .fd_match_i, .fd_queue_i, .dec_valid_o,
    .dec_queue_o, .dec_pool_o, .dec_pool_off_o, .dec_etf_hit_o,
    .dec_etf_id_o, .dec_timestamp_o, .dec_host_force_o);
  rxqa_dma_sink u_rxqa_dma_sink (.sys_clk_i, .nrst_i,
    .dec_valid_i(dec_valid_o), .dec_queue_i(dec_queue_o),
    .dec_flags_i({dec_pool_off_o, dec_etf_hit_o, dec_timestamp_o}),
    .dec_id_i(dec_etf_id_o), .got_q_o(got_q), .got_fl_o(got_fl),
    .got_id_o(got_id), .prev_q_o(prev_q));

  always #10 sys_clk_i = ~sys_clk_i;

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic final_report;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_write_i     <= w;
    avs_read_i      <= !w;
    avs_address_i   <= a;
    avs_writedata_i <= d;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0)
    begin
      fails++;
      final_report();
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask

  task automatic drv(input logic [15:0] et, input logic [5:0] pool,
    input logic mir, input logic [6:0] h, input logic s, input logic [6:0] sq,
    input logic f, input logic [6:0] fq);
    @(posedge sys_clk_i);
    pkt_ethertype_i <= et;
    pkt_pool_i      <= pool;
    pkt_mirror_i    <= mir;
    pkt_hash_i      <= h;
    syn_match_i     <= s;
    syn_queue_i     <= sq;
    fd_match_i      <= f;
    fd_queue_i      <= fq;
    pkt_valid_i     <= 1'b1;
    ndec++;
  endtask

  task automatic done;
    @(posedge sys_clk_i);
    pkt_valid_i <= 1'b0;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask

  task automatic dchk(input logic [6:0] q, input logic [2:0] fl,
    input logic [2:0] id);
    cmp({19'h0, got_q, got_fl, got_id}, {19'h0, q, fl, id});
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    {sys_clk_i, nrst_i, avs_read_i, avs_write_i, pkt_valid_i} = 5'h00;
    {pkt_mirror_i, syn_match_i, fd_match_i} = 3'h0;
    {avs_address_i, avs_writedata_i, pkt_ethertype_i} = 56'h0;
    {pkt_hash_i, syn_queue_i, fd_queue_i, pkt_pool_i} = 27'h0;
    fails = 0;
    samples_checked = 0;
    ndec = 0;
    repeat (20) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rchk(8'h00, rxqa_pkg::RST_MATCH);
    rchk(8'h3C, rxqa_pkg::RST_STEER);
    rchk(8'h4C, 32'h0);
    bus(1'b1, 8'h00, 32'hC000_88F7);
    bus(1'b1, 8'h20, 32'h8005_0000);
    bus(1'b1, 8'h0C, 32'h8450_888E);
    bus(1'b1, 8'h2C, 32'h800A_0000);
    bus(1'b1, 8'h1C, 32'h8000_88CC);
    bus(1'b1, 8'h3C, 32'h0033_0000);
    bus(1'b1, 8'h04, 32'h0000_1234);
    bus(1'b1, 8'h24, 32'h8033_0000);
    rchk(8'h0C, 32'h8450_888E);
    foreach (rows[i])
    begin
      bus(1'b1, 8'h40, {28'h0, rows[i].sch});
      bus(1'b1, 8'h44, {31'h0, rows[i].vt});
      drv(rows[i].et, rows[i].pool, 1'b0, rows[i].hash, 1'b0, 7'h0, 1'b0, 7'h0);
      done();
      dchk(rows[i].q, rows[i].fl, rows[i].id);
    end
    rchk(8'h40, 32'h0000_000E);
    drv(16'h888E, 6'h04, 1'b1, 7'h00, 1'b0, 7'h0, 1'b0, 7'h0);
    done();
    dchk(7'h08, 3'h2, 3'h3);
    cmp({26'h0, dec_pool_o}, 32'h4);
    drv(16'h888E, 6'h04, 1'b0, 7'h00, 1'b0, 7'h0, 1'b0, 7'h0);
    done();
    cmp({26'h0, dec_pool_o}, 32'h5);
    bus(1'b1, 8'h40, 32'h0000_0001);
    bus(1'b1, 8'h44, 32'h0000_0000);
    drv(16'h88F7, 6'h00, 1'b0, 7'h01, 1'b1, 7'h40, 1'b1, 7'h50);
    done();
    dchk(7'h05, 3'h3, 3'h0);
    drv(16'h0800, 6'h00, 1'b0, 7'h01, 1'b1, 7'h40, 1'b1, 7'h50);
    done();
    dchk(7'h40, 3'h0, 3'h0);
    drv(16'h0800, 6'h00, 1'b1, 7'h01, 1'b1, 7'h40, 1'b1, 7'h50);
    done();
    dchk(7'h50, 3'h0, 3'h0);
    drv(16'h0800, 6'h00, 1'b0, 7'h03, 1'b0, 7'h00, 1'b0, 7'h00);
    drv(16'h88F7, 6'h00, 1'b0, 7'h03, 1'b0, 7'h00, 1'b0, 7'h00);
    done();
    cmp({25'h0, prev_q}, 32'h3);
    dchk(7'h05, 3'h3, 3'h0);
    rchk(8'h48, {ndec[15:0], 9'h0, 7'h05});
    @(posedge sys_clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    cmp(avs_readdata_o, 32'h0);
    cmp({31'h0, avs_waitrequest_o}, 32'h1);
    cmp({18'h0, dec_valid_o, dec_queue_o, dec_pool_o}, 32'h0);
    @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    rchk(8'h0C, rxqa_pkg::RST_MATCH);
    rchk(8'h48, 32'h0);
    final_report();
  end
endmodule // rxqa_core_tb

// ===== rxqa_dma_sink.sv
/*
  Receive DMA stand-in: captures each queue decision when it is offered.
  Assumes decisions arrive as one-cycle pulses on sys_clk_i.
*/
module rxqa_dma_sink
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       dec_valid_i,
  input  wire logic [6:0] dec_queue_i,
  input  wire logic [2:0] dec_flags_i,
  input  wire logic [2:0] dec_id_i,
  output logic      [6:0] got_q_o,
  output logic      [2:0] got_fl_o,
  output logic      [2:0] got_id_o,
  output logic      [6:0] prev_q_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      got_q_o  <= 7'h00;
      got_fl_o <= 3'h0;
      got_id_o <= 3'h0;
      prev_q_o <= 7'h00;
    end
    else if (dec_valid_i)
    begin
      prev_q_o <= got_q_o;
      got_q_o  <= dec_queue_i;
      got_fl_o <= dec_flags_i;
      got_id_o <= dec_id_i;
    end
  end
endmodule // rxqa_dma_sink

// ===== rxqa_monitor.sv
/*
  Port checker for rxqa_core: decision latency, priority, hold and bus
  answer timing.
  Assumes it is bound to every rxqa_core instance, one clock domain.
*/
module rxqa_monitor
(
  input  wire logic       sys_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       avs_read_i,
  input  wire logic       avs_write_i,
  input  wire logic       avs_waitrequest_o,
  input  wire logic       pkt_valid_i,
  input  wire logic       pkt_mirror_i,
  input  wire logic       syn_match_i,
  input  wire logic [6:0] syn_queue_i,
  input  wire logic       fd_match_i,
  input  wire logic [6:0] fd_queue_i,
  input  wire logic       dec_valid_o,
  input  wire logic [6:0] dec_queue_o,
  input  wire logic       dec_pool_off_o,
  input  wire logic       dec_etf_hit_o,
  input  wire logic [2:0] dec_etf_id_o,
  input  wire logic       dec_timestamp_o,
  input  wire logic       dec_host_force_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);

  AST_DEC_LAT:
  assert property (pkt_valid_i |=> dec_valid_o) else $error("late decision");
  AST_DEC_HOLD:
  assert property (!pkt_valid_i |=> !dec_valid_o && $stable(dec_queue_o))
    else $error("decision moved without request");
  AST_BUS_ANS:
  assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer");
  AST_SYN_PRIO:
  assert property (pkt_valid_i && syn_match_i && !pkt_mirror_i
    ##1 !dec_etf_hit_o && !dec_pool_off_o |-> dec_queue_o == $past(syn_queue_i))
    else $error("syn queue not taken");
  AST_FD_PRIO:
  assert property (pkt_valid_i && fd_match_i && (!syn_match_i || pkt_mirror_i)
    ##1 !dec_etf_hit_o && !dec_pool_off_o |-> dec_queue_o == $past(fd_queue_i))
    else $error("flow queue not taken");
  AST_ETF_ID:
  assert property (dec_valid_o && !dec_etf_hit_o |-> dec_etf_id_o == 3'h0)
    else $error("filter id without hit");
  AST_HOST:
  assert property (dec_valid_o |-> dec_host_force_o == dec_etf_hit_o)
    else $error("host force mismatch");
  AST_TSTAMP:
  assert property (dec_valid_o && dec_timestamp_o |-> dec_etf_hit_o)
    else $error("time stamp without hit");
  AST_POOL_OFF:
  assert property (dec_valid_o && dec_pool_off_o |-> dec_queue_o == 7'h00)
    else $error("disabled pool got queue");
endmodule // rxqa_monitor

bind rxqa_core rxqa_monitor u_rxqa_monitor (.sys_clk_i, .nrst_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .pkt_valid_i, .pkt_mirror_i, .syn_match_i,
  .syn_queue_i, .fd_match_i, .fd_queue_i, .dec_valid_o, .dec_queue_o,
  .dec_pool_off_o, .dec_etf_hit_o, .dec_etf_id_o, .dec_timestamp_o,
  .dec_host_force_o);

// ===== rxqa_pkg.sv
/*
  Constants for the receive queue assignment block: register map, field
  positions, reset values and queuing scheme codes.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package rxqa_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          NUM_ETF      = 8;
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_MATCH    = 8'h00;
  localparam logic [7:0]  OFS_STEER    = 8'h20;
  localparam logic [7:0]  OFS_MQC      = 8'h40;
  localparam logic [7:0]  OFS_VTCTL    = 8'h44;
  localparam logic [7:0]  OFS_STATUS   = 8'h48;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int          MT_TYPE_LSB  = 0;
  localparam int          MT_POOL_LSB  = 20;
  localparam int          MT_POOL_EN   = 26;
  localparam int          MT_TSTAMP    = 30;
  localparam int          MT_ENABLE    = 31;
  localparam int          ST_QUEUE_LSB = 16;
  localparam int          ST_QUEUE_EN  = 31;
  localparam int          MQC_SCH_LSB  = 0;
  localparam int          VT_EN_BIT    = 0;
  localparam int          STS_Q_LSB    = 0;
  localparam int          STS_CNT_LSB  = 16;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] RST_MATCH    = 32'h0000_0000;
  localparam logic [31:0] RST_STEER    = 32'h0000_0000;
  localparam logic [3:0]  RST_SCHEME   = 4'h0;
  localparam logic        RST_VT_EN    = 1'b0;

  // ----------------------------------------------------------------------
  // Queuing scheme codes
  // ----------------------------------------------------------------------
  localparam logic [3:0]  SCH_NOHASH   = 4'h0;
  localparam logic [3:0]  SCH_HASH     = 4'h1;
  localparam logic [3:0]  SCH_VT_P63   = 4'h0;
  localparam logic [3:0]  SCH_VT_H32   = 4'hA;
  localparam logic [3:0]  SCH_VT_H64   = 4'hB;
  localparam logic [3:0]  SCH_VT_N16   = 4'hC;
  localparam logic [3:0]  SCH_VT_N32   = 4'hD;
  localparam logic [3:0]  SCH_VT_N64   = 4'hE;
  localparam logic [3:0]  SCH_VT_P62   = 4'hF;

  // ----------------------------------------------------------------------
  // Special pool numbers of the 62 and 63 pool layouts
  // ----------------------------------------------------------------------
  localparam logic [5:0]  POOL_WIDE_LO = 6'h3C;
  localparam logic [5:0]  POOL_WIDE_HI = 6'h3E;
  localparam logic [5:0]  POOL_OFF_LO  = 6'h3D;
  localparam logic [5:0]  POOL_OFF_HI  = 6'h3F;

endpackage
